// *** rtl/vxi_control_and_offset_regs.sv ***
// configuration control, status mirror and wide-space base offset register bank
`timescale 1ns/100ps
`include "vxi_cfg_map.svh"
module vxi_control_and_offset_regs (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic cfg_sel_in,
  input wire logic cfg_write_in,
  input wire logic [15:0] cfg_offset_in,
  input wire logic [3:0] cfg_byte_en_in,
  input wire logic [31:0] cfg_wdata_in,
  input wire logic cfg_from_cable_in,
  output logic [31:0] cfg_rdata_out,
  input wire logic init_passed_in,
  input wire logic init_ready_in,
  input wire logic forced_sysfail_bit_in,
  input wire logic cable_sysfail_in,
  input wire vxi_cfg_pkg::wide_access_t wide_access_in,
  input wire logic [3:0] memory_size_request_field_in,
  output logic wide_hit_out,
  output logic soft_reset_out,
  output logic sysfail_out
);
  // ************************************************
  // control bits
  // ************************************************
  vxi_cfg_pkg::ctrl_bits_t ctrl_q;
  logic [15:0] base_q;
  logic wr_ctrl;
  logic wr_base;
  logic [15:0] st_word;
  logic pass_q1, pass_q;
  logic cab_q1, cab_q;
  logic rdy_q1, rdy_q;

  // bridge inputs come from another domain, so two flops first
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pass_q1 <= 1'b0;
      pass_q <= 1'b0;
      cab_q1 <= 1'b0;
      cab_q <= 1'b0;
      rdy_q1 <= 1'b0;
      rdy_q <= 1'b0;
    end else begin
      pass_q1 <= init_passed_in;
      pass_q <= pass_q1;
      cab_q1 <= cable_sysfail_in;
      cab_q <= cab_q1;
      rdy_q1 <= init_ready_in;
      rdy_q <= rdy_q1;
    end
  end

  assign wr_ctrl = cfg_sel_in && cfg_write_in && cfg_offset_in == `CTRL_REG_OFFSET;
  assign wr_base = cfg_sel_in && cfg_write_in
                   && (cfg_offset_in == `BASE_OFFSET_REG_OFFSET
                       || cfg_offset_in == `CTRL_REG_OFFSET);

  // control lives in the upper lanes; 16/8-bit writes put it on lanes 3:2
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl_q <= '0;
    end else if (wr_ctrl) begin
      if (cfg_byte_en_in[3]) begin
        ctrl_q.decode_en <= cfg_wdata_in[16 + `CTRL_DECODE_EN_BIT];
      end
      if (cfg_byte_en_in[2]) begin
        ctrl_q.sf_inhibit <= cfg_wdata_in[16 + `CTRL_SF_INHIBIT_BIT];
        // entry only before init completes; clearing always allowed
        if (!pass_q || !cfg_wdata_in[16 + `CTRL_SOFT_RESET_BIT]) begin
          ctrl_q.soft_reset <= cfg_wdata_in[16 + `CTRL_SOFT_RESET_BIT];
        end
      end
    end
  end

  // reserved bits 14..2 are written as ones by the master; not stored

  // ************************************************
  // base offset
  // ************************************************
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      base_q <= `BASE_OFFSET_RESET;
    end else if (wr_base) begin
      if (cfg_byte_en_in[1]) base_q[15:8] <= cfg_wdata_in[15:8];
      if (cfg_byte_en_in[0]) base_q[7:0] <= cfg_wdata_in[7:0];
    end
  end

  // ************************************************
  // read path
  // ************************************************
  assign st_word = {ctrl_q.decode_en, 1'b1, `STAT_EDTYPE_VALUE, 1'b0, cfg_from_cable_in,
                    `STAT_VERSION_VALUE, rdy_q, pass_q,
                    ctrl_q.sf_inhibit, ctrl_q.soft_reset};

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cfg_rdata_out <= 32'h0000_0000;
    end else if (cfg_sel_in && !cfg_write_in) begin
      if (cfg_offset_in == `CTRL_REG_OFFSET) begin
        cfg_rdata_out <= {st_word, base_q};
      end else if (cfg_offset_in == `BASE_OFFSET_REG_OFFSET) begin
        cfg_rdata_out <= {16'h0000, base_q};
      end else begin
        cfg_rdata_out <= 32'h0000_0000;
      end
    end
  end

  // ************************************************
  // wide-space decoder
  // ************************************************
  function automatic logic match_top(input logic [15:0] off, input logic [15:0] lines,
                                     input logic [3:0] req);
    logic [15:0] mask;
    mask = ~(16'hffff >> ({1'b0, req} + 5'h01));
    return ((off ^ lines) & mask) == 16'h0000;
  endfunction : match_top

  logic [15:0] sel_lines;
  assign sel_lines = wide_access_in.wide32 ? wide_access_in.addr[31:16]
                                           : wide_access_in.addr[23:8];
  // same offset for both buses; registered values used from next cycle
  assign wide_hit_out = ctrl_q.decode_en
                        && match_top(base_q, sel_lines, memory_size_request_field_in);

  assign soft_reset_out = ctrl_q.soft_reset;
  assign sysfail_out = (!pass_q && !ctrl_q.sf_inhibit) || forced_sysfail_bit_in
                       || cab_q;

  // ************************************************
  // sequences shared by the checks
  // ************************************************
  sequence s_ctrl_upper_write;
    wr_ctrl && cfg_byte_en_in[2];
  endsequence

  sequence s_soft_request;
    wr_ctrl && cfg_byte_en_in[2] && cfg_wdata_in[16];
  endsequence

  sequence s_soft_release;
    wr_ctrl && cfg_byte_en_in[2] && !cfg_wdata_in[16];
  endsequence

  sequence s_status_read;
    cfg_sel_in && !cfg_write_in && cfg_offset_in == `CTRL_REG_OFFSET;
  endsequence

  sequence s_offset_read;
    cfg_sel_in && !cfg_write_in && cfg_offset_in == `BASE_OFFSET_REG_OFFSET;
  endsequence

  // ************************************************
  // checks
  // ************************************************
  a_decode_gate: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !ctrl_q.decode_en |-> !wide_hit_out)
    else $error("hit while decode disabled");
  a_softrst_locked: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (pass_q && !ctrl_q.soft_reset) |=> !ctrl_q.soft_reset)
    else $error("soft reset after pass");
  a_softrst_refused: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    s_soft_request ##0 (pass_q && !ctrl_q.soft_reset) |=> !ctrl_q.soft_reset)
    else $error("soft reset request not refused");
  a_softrst_entry: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    s_soft_request ##0 !pass_q |=> ctrl_q.soft_reset)
    else $error("soft reset not entered");
  a_softrst_clear: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    s_soft_release |=> !ctrl_q.soft_reset)
    else $error("soft reset not left");
  a_enable_write: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (wr_ctrl && cfg_byte_en_in[3]) |=> ctrl_q.decode_en == $past(cfg_wdata_in[31]))
    else $error("decode enable not written");
  a_inhibit_write: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    s_ctrl_upper_write |=> ctrl_q.sf_inhibit == $past(cfg_wdata_in[17]))
    else $error("sysfail inhibit not written");
  a_offset_write: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (wr_base && cfg_byte_en_in[0]) |=> base_q[7:0] == $past(cfg_wdata_in[7:0]))
    else $error("offset low byte not written");
  a_offset_high: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (wr_base && cfg_byte_en_in[1]) |=> base_q[15:8] == $past(cfg_wdata_in[15:8]))
    else $error("offset high byte not written");
  // only a write or a hard reset may move the offset
  a_offset_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !wr_base |=> $stable(base_q))
    else $error("offset changed without write");
  a_sysfail_init: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (!pass_q && !ctrl_q.sf_inhibit) |-> sysfail_out)
    else $error("sysfail missing");
  a_sysfail_forced: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    forced_sysfail_bit_in |-> sysfail_out)
    else $error("forced sysfail lost");
  a_sysfail_cable: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    cab_q |-> sysfail_out)
    else $error("inward sysfail lost");
  a_inhibit_mask: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (ctrl_q.sf_inhibit && !forced_sysfail_bit_in && !cab_q) |-> !sysfail_out)
    else $error("sysfail driven while inhibited");
  // with decoding enabled, a full match of all offset bits on a non-wide32 access must hit whatever the size field says
  a_hit_exact: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (ctrl_q.decode_en && !wide_access_in.wide32 && wide_access_in.addr[23:8] == base_q)
    |-> wide_hit_out) else $error("hit missing on exact match");
  a_hit_topbit: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (!wide_access_in.wide32 && wide_access_in.addr[23] != base_q[15]) |-> !wide_hit_out)
    else $error("hit on top bit mismatch");
  a_status_mirror: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    s_status_read |=> cfg_rdata_out[17:16] == $past({ctrl_q.sf_inhibit, ctrl_q.soft_reset}))
    else $error("status mirror wrong");
  a_status_offset: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    s_status_read |=> cfg_rdata_out[15:0] == $past(base_q))
    else $error("offset missing from wide status read");
  a_read_offset: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    s_offset_read |=> cfg_rdata_out == {16'h0000, $past(base_q)})
    else $error("offset read wrong");
endmodule : vxi_control_and_offset_regs

// *** rtl/vxi_cfg_map.svh ***
// register offsets, field positions and reset values of the configuration registers
`ifndef VXI_CFG_MAP_SVH
`define VXI_CFG_MAP_SVH
`define CTRL_REG_OFFSET 16'h0004
`define BASE_OFFSET_REG_OFFSET 16'h0006
`define CTRL_DECODE_EN_BIT 15
`define CTRL_SF_INHIBIT_BIT 1
`define CTRL_SOFT_RESET_BIT 0
`define STAT_MODID_BIT 14
`define STAT_EDTYPE_VALUE 4'he
`define STAT_VERSION_VALUE 4'hf
`define BASE_OFFSET_RESET 16'h0000
`endif

// *** rtl/vxi_cfg_pkg.sv ***
// types shared by the configuration register bank
package vxi_cfg_pkg;
  typedef struct packed {
    logic decode_en;
    logic sf_inhibit;
    logic soft_reset;
  } ctrl_bits_t;

  typedef struct packed {
    logic [31:0] addr;
    logic wide32;
  } wide_access_t;
endpackage : vxi_cfg_pkg

// *** sim/cfg_master.sv ***
// bus master model issuing configuration register cycles
`timescale 1ns/100ps
module cfg_master (
  input wire logic clk_in,
  output logic sel_out,
  output logic write_out,
  output logic [15:0] offset_out,
  output logic [3:0] be_out,
  output logic [31:0] wdata_out
);
  initial begin
    {sel_out, write_out, offset_out, be_out, wdata_out} = '0;
  end
  // one access; ends one edge after the taking edge, outputs settled
  task acc(input logic w, input logic [15:0] off, input logic [3:0] be, input logic [31:0] d);
    @(posedge clk_in);
    sel_out <= 1'b1;
    write_out <= w;
    offset_out <= off;
    be_out <= be;
    wdata_out <= (be[3:2] != 2'b00) ? (d | 32'h7ffc_0000) : d;
    @(posedge clk_in);
    sel_out <= 1'b0;
    wdata_out <= ~d;
    @(posedge clk_in);
    #1;
  endtask : acc
endmodule : cfg_master

// *** sim/vxi_control_and_offset_regs_tb.sv ***
// self-checking bench for the configuration register bank
`timescale 1ns/100ps
module vxi_control_and_offset_regs_tb;
  // ****
  // stimulus and checks
  // ****
  logic clk_in, rst_n_in, sel, wr, cab, ps, rdy, frc, csf, hit, srst, sf;
  logic [15:0] off;
  logic [3:0] be, msr;
  logic [31:0] wd, rd;
  vxi_cfg_pkg::wide_access_t wa;
  int n_fail = 0;
  int n_tests = 0;
  cfg_master m (.clk_in(clk_in), .sel_out(sel), .write_out(wr), .offset_out(off),
    .be_out(be), .wdata_out(wd));
  vxi_control_and_offset_regs uut (.clk_in(clk_in), .rst_n_in(rst_n_in), .cfg_sel_in(sel),
    .cfg_write_in(wr), .cfg_offset_in(off), .cfg_byte_en_in(be), .cfg_wdata_in(wd),
    .cfg_from_cable_in(cab), .cfg_rdata_out(rd), .init_passed_in(ps), .init_ready_in(rdy),
    .forced_sysfail_bit_in(frc), .cable_sysfail_in(csf), .wide_access_in(wa),
    .memory_size_request_field_in(msr), .wide_hit_out(hit), .soft_reset_out(srst),
    .sysfail_out(sf));
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task conclude;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : conclude
  task hard_reset;
    @(posedge clk_in);
    rst_n_in <= 1'b0;
    repeat (12) @(posedge clk_in);
    rst_n_in <= 1'b1;
    #1;
  endtask : hard_reset
  task wide(input logic [31:0] a, input logic w, input logic exp);
    @(posedge clk_in);
    wa <= '{addr: a, wide32: w};
    @(posedge clk_in);
    #1;
    chk("wide hit", {31'h0, hit}, {31'h0, exp});
  endtask : wide
  task pause(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : pause
  initial begin
    {rst_n_in, cab, ps, rdy, frc, csf} = '0;
    wa = '0;
    msr = 4'h3;
    hard_reset();
    chk("sysfail", {31'h0, sf}, 32'h1);
    m.acc(1'b0, 16'h0006, 4'h3, 32'h0);
    chk("offset", rd, 32'h0);
    m.acc(1'b1, 16'h0004, 4'hf, 32'h8003_1234);
    chk("soft reset", {31'h0, srst}, 32'h1);
    chk("sysfail", {31'h0, sf}, 32'h0);
    m.acc(1'b0, 16'h0004, 4'hf, 32'h0);
    chk("status", rd, 32'hf8f3_1234);
    wide(32'h001f_ffff, 1'b0, 1'b1);
    wide(32'h0012_3400, 1'b0, 1'b1);
    wide(32'h0092_3400, 1'b0, 1'b0);
    wide(32'h002f_ffff, 1'b0, 1'b0);
    @(posedge clk_in) cab <= 1'b1;
    wide(32'h1000_0000, 1'b1, 1'b1);
    wide(32'h0010_0000, 1'b1, 1'b0);
    @(posedge clk_in) frc <= 1'b1;
    pause(3);
    chk("forced sysfail", {31'h0, sf}, 32'h1);
    @(posedge clk_in) {frc, csf} <= 2'b01;
    pause(4);
    chk("cable sysfail", {31'h0, sf}, 32'h1);
    @(posedge clk_in) csf <= 1'b0;
    m.acc(1'b1, 16'h0004, 4'hc, 32'h0);
    chk("soft reset", {31'h0, srst}, 32'h0);
    chk("sysfail", {31'h0, sf}, 32'h1);
    wide(32'h1000_0000, 1'b1, 1'b0);
    @(posedge clk_in) ps <= 1'b1;
    pause(4);
    chk("sysfail", {31'h0, sf}, 32'h0);
    m.acc(1'b1, 16'h0004, 4'hc, 32'h0001_0000);
    chk("soft reset", {31'h0, srst}, 32'h0);
    m.acc(1'b1, 16'h0006, 4'h3, 32'h0000_abcd);
    m.acc(1'b1, 16'h0006, 4'h1, 32'h0000_0055);
    m.acc(1'b1, 16'h0008, 4'hf, 32'hffff_ffff);
    m.acc(1'b0, 16'h0006, 4'h3, 32'h0);
    chk("offset", rd, 32'h0000_ab55);
    m.acc(1'b0, 16'h0008, 4'hf, 32'h0);
    chk("unmapped", rd, 32'h0);
    @(posedge clk_in) {ps, cab} <= 2'b00;
    hard_reset();
    m.acc(1'b0, 16'h0004, 4'hf, 32'h0);
    chk("status", rd, 32'h78f0_0000);
    conclude();
  end
endmodule : vxi_control_and_offset_regs_tb
